// *** include/ias_regs.vh ***
/*
 * Constants of the interrupt acceptance sequencer: register offsets,
 * status word layout, reset values and sequence step numbers.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef IAS_REGS_VH
`define IAS_REGS_VH

// ****************************************************************
// sizes
// ****************************************************************
`define IAS_NSRC        8
`define IAS_NGPR        8

// ****************************************************************
// register byte offsets on the apb slave
// ****************************************************************
`define IAS_ADDR_CTRL   8'h00
`define IAS_ADDR_PEND   8'h04
`define IAS_ADDR_ENAB   8'h08
`define IAS_ADDR_PRIO   8'h0C
`define IAS_ADDR_STACK  8'h10
`define IAS_ADDR_STAT   8'h14
`define IAS_ADDR_VBASE  8'h18

// ctrl register fields
`define IAS_CTRL_MIE    0
`define IAS_CTRL_BANK   1

// ****************************************************************
// status word layout
// ****************************************************************
`define IAS_SW_MIE      7
`define IAS_SW_BANK     0

// ****************************************************************
// reset values
// ****************************************************************
`define IAS_STACK_RST   16'h00FF
`define IAS_VBASE_RST   16'hFFC0

// ****************************************************************
// sequence steps
// ****************************************************************
`define IAS_ACC_SW      3'h0
`define IAS_ACC_HI      3'h1
`define IAS_ACC_LO      3'h2
`define IAS_ACC_VRLO    3'h3
`define IAS_ACC_VRHI    3'h4
`define IAS_ACC_VCLO    3'h5
`define IAS_ACC_VCHI    3'h6
`define IAS_ACC_LAST    3'h7
`define IAS_RET_RD2     3'h2
`define IAS_RET_CAPHI   3'h3
`define IAS_RET_LAST    3'h4
`define IAS_STACK_POP3  16'h0003
`define IAS_NMI_SLOT    4'h0

`endif

// *** hdl/ias_prio_arb.v ***
/*
 * Priority picker for the maskable sources: highest level wins,
 * a tie goes to the higher source index.
 * Assumes requests already gated by the per-source enables.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ias_regs.vh"

module ias_prio_arb
(
  // requests and levels
  input  wire [`IAS_NSRC-1:0]   req,
  input  wire [2*`IAS_NSRC-1:0] level,
  // winner
  output reg                    win_valid,
  output reg  [2:0]             win_idx
);

  // ****************************************************************
  // level of one source
  // ****************************************************************
  function [1:0] ias_level_of;
    input [2*`IAS_NSRC-1:0] lv;
    input integer           n;
    begin
      ias_level_of = lv[2*n +: 2];
    end
  endfunction

  integer    i;
  reg  [1:0] best_lvl;

  always @*
  begin
    win_valid = 1'b0;
    win_idx   = 3'h0;
    best_lvl  = 2'h0;
    for (i = 0; i < `IAS_NSRC; i = i + 1)
    begin
      if (req[i] && (!win_valid || ias_level_of(level, i) >= best_lvl))
      begin
        win_valid = 1'b1;
        win_idx   = i[2:0];
        best_lvl  = ias_level_of(level, i);
      end
    end
  end

endmodule
`default_nettype wire

// *** hdl/ias_bank_file.v ***
/*
 * Two switchable banks of eight byte registers and two 16-bit index
 * registers each; the active bank comes from the bank select.
 * Assumes write and read indexes from cpu logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ias_regs.vh"

module ias_bank_file
(
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // bank choice
  input  wire        bank_select,
  // byte registers
  input  wire        gpr_we,
  input  wire [2:0]  gpr_idx,
  input  wire [7:0]  gpr_wdata,
  output reg  [7:0]  gpr_rdata,
  // index registers, sel 0 is x, 1 is y
  input  wire        index_we,
  input  wire        index_sel,
  input  wire [15:0] index_wdata,
  output reg  [15:0] index_rdata
);

  reg  [7:0]  gpr_mem_r   [0:2*`IAS_NGPR-1];
  reg  [15:0] index_mem_r [0:3];
  wire [3:0]  gpr_addr;
  wire [1:0]  index_addr;
  integer     k;

  assign gpr_addr   = {bank_select, gpr_idx};
  assign index_addr = {bank_select, index_sel};

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (k = 0; k < 2*`IAS_NGPR; k = k + 1)
        gpr_mem_r[k] <= 8'h00;
      for (k = 0; k < 4; k = k + 1)
        index_mem_r[k] <= 16'h0000;
      gpr_rdata   <= 8'h00;
      index_rdata <= 16'h0000;
    end
    else
    begin
      if (gpr_we)
        gpr_mem_r[gpr_addr] <= gpr_wdata;
      if (index_we)
        index_mem_r[index_addr] <= index_wdata;
      gpr_rdata   <= gpr_mem_r[gpr_addr];
      index_rdata <= index_mem_r[index_addr];
    end
  end

endmodule
`default_nettype wire

// *** hdl/ias_top.v ***
/*
 * Interrupt acceptance and return sequencer with stack pointer, apb
 * registers and the banked general register file.
 * Assumes cpu strobes, sources and stack memory on pclk; memory read
 * data is valid in the cycle after mem_re is high.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ias_regs.vh"

// Notes on behaviour
// - a latched request stays until accepted, reset, or cleared by software
// - acceptance starts after instruction completion and lasts 8 cycles
// - service ends on return_from_maskable or return_from_nonmaskable
// - 16-bit stack_ptr decrements after every push
// - stack_ptr increments before every stack read by return or pop
// - stack_ptr resets to 00FF
// - first acceptance step clears master_irq_enable
// - acceptance clears only the accepted source's pending latch
// - acceptance pushes status word, high byte, low byte; stack_ptr minus 3
// - counter then loads the vector entry of the accepted source
// - saved status word holds bank select and master enable
// - no maskable acceptance while master enable is low
// - only counter and status word are saved automatically
// - return_from_maskable restores the bank from the popped status word
// - two banks of eight byte registers plus two index registers
// - highest 2-bit level wins, ties to higher source index
// - maskable acceptance needs master enable and source enable
// - writing 0 clears a latch, writing 1 changes nothing
module ias_top
(
  // clock and reset
  input  wire                 pclk,
  input  wire                 presetn,
  // apb slave
  input  wire [7:0]           paddr,
  input  wire                 psel,
  input  wire                 penable,
  input  wire                 pwrite,
  input  wire [31:0]          pwdata,
  output reg  [31:0]          prdata,
  output reg                  pready,
  output reg                  pslverr,
  // interrupt sources, one-cycle pulses
  input  wire [`IAS_NSRC-1:0] irq_pulse,
  input  wire                 nmi_pulse,
  // cpu execution strobes
  input  wire                 instr_done,
  input  wire [15:0]          counter_now,
  input  wire                 return_from_maskable,
  input  wire                 return_from_nonmaskable,
  input  wire                 push_req,
  input  wire [7:0]           push_data,
  input  wire                 pop_req,
  input  wire                 enable_irq,
  input  wire                 disable_irq,
  input  wire                 bank_wr,
  input  wire                 bank_wdata,
  // general registers
  input  wire                 gpr_we,
  input  wire [2:0]           gpr_idx,
  input  wire [7:0]           gpr_wdata,
  output wire [7:0]           gpr_rdata,
  input  wire                 index_we,
  input  wire                 index_sel,
  input  wire [15:0]          index_wdata,
  output wire [15:0]          index_rdata,
  // stack and vector memory port
  input  wire [7:0]           mem_rdata,
  output reg                  mem_we,
  output reg                  mem_re,
  output reg  [15:0]          mem_addr,
  output reg  [7:0]           mem_wdata,
  // to cpu
  output reg                  seq_busy,
  output reg                  counter_load,
  output reg  [15:0]          counter_val,
  output reg                  bank_select,
  output reg                  master_irq_enable
);

  // ****************************************************************
  // states
  // ****************************************************************
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_ACC  = 3'b010;
  localparam [2:0] ST_RET  = 3'b100;

  reg  [2:0]            state_r;
  reg  [2:0]            step_r;
  reg  [15:0]           stack_ptr_r;
  reg  [15:0]           vbase_r;
  reg  [15:0]           vec_addr_r;
  reg  [15:0]           saved_cnt_r;
  reg  [7:0]            vec_lo_r;
  reg  [7:0]            pop_lo_r;
  reg  [7:0]            pop_hi_r;
  reg  [7:0]            rdata_dly_r;
  reg  [`IAS_NSRC-1:0]  pending_latch_r;
  reg  [`IAS_NSRC-1:0]  source_enable_flag_r;
  reg  [2*`IAS_NSRC-1:0] priority_level_field_r;
  reg                   nmi_pend_r;
  reg                   svc_mask_r;
  reg                   svc_nmi_r;
  reg                   acc_nmi_r;
  reg  [3:0]            last_slot_r;
  reg  [7:0]            status_word;
  reg  [31:0]           rd_mux;

  wire                  win_valid;
  wire [2:0]            win_idx;
  wire                  take_nmi;
  wire                  accept_go;
  wire                  return_go;
  wire                  idle;
  wire [3:0]            slot;
  wire [`IAS_NSRC-1:0]  acc_clear;
  wire [`IAS_NSRC-1:0]  apb_clear;
  wire                  wr_en;

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  function [`IAS_NSRC-1:0] ias_onehot;
    input [2:0] idx;
    begin
      ias_onehot      = {`IAS_NSRC{1'b0}};
      ias_onehot[idx] = 1'b1;
    end
  endfunction

  function ias_mapped;
    input [7:0] a;
    begin
      case (a)
        `IAS_ADDR_CTRL, `IAS_ADDR_PEND, `IAS_ADDR_ENAB, `IAS_ADDR_PRIO,
        `IAS_ADDR_STACK, `IAS_ADDR_STAT, `IAS_ADDR_VBASE: ias_mapped = 1'b1;
        default: ias_mapped = 1'b0;
      endcase
    end
  endfunction

  // ****************************************************************
  // request selection
  // ****************************************************************
  // both enables gate a source
  ias_prio_arb u_arb
  (
    .req       (pending_latch_r & source_enable_flag_r),
    .level     (priority_level_field_r),
    .win_valid (win_valid),
    .win_idx   (win_idx)
  );

  assign idle     = (state_r == ST_IDLE);
  assign take_nmi = nmi_pend_r;
  assign accept_go = idle && instr_done && (take_nmi || (master_irq_enable && win_valid));
  assign return_go = idle && !accept_go
                     && (return_from_maskable || return_from_nonmaskable);
  assign slot      = take_nmi ? `IAS_NMI_SLOT : {1'b0, win_idx} + 4'h1;
  assign acc_clear = (accept_go && !take_nmi) ? ias_onehot(win_idx) : {`IAS_NSRC{1'b0}};
  assign wr_en     = psel && penable && pready && pwrite && !pslverr;
  assign apb_clear = (wr_en && paddr == `IAS_ADDR_PEND) ? ~pwdata[`IAS_NSRC-1:0]
                                                      : {`IAS_NSRC{1'b0}};

  // ****************************************************************
  // pending latches, a new event wins over any clear
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < `IAS_NSRC; g = g + 1)
    begin : g_latch
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          pending_latch_r[g] <= 1'b0;
        else if (irq_pulse[g])
          pending_latch_r[g] <= 1'b1;
        else if (acc_clear[g] || apb_clear[g])
          pending_latch_r[g] <= 1'b0;
      end
    end
  endgenerate

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      nmi_pend_r <= 1'b0;
    else if (nmi_pulse)
      nmi_pend_r <= 1'b1;
    else if (accept_go)
      nmi_pend_r <= 1'b0;
  end

  always @*
  begin
    status_word                = 8'h00;
    status_word[`IAS_SW_MIE]   = master_irq_enable;
    status_word[`IAS_SW_BANK]  = bank_select;
  end

  // ****************************************************************
  // acceptance and return sequencer
  // ****************************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r           <= ST_IDLE;
      step_r            <= 3'h0;
      stack_ptr_r       <= `IAS_STACK_RST;
      vec_addr_r        <= 16'h0000;
      saved_cnt_r       <= 16'h0000;
      vec_lo_r          <= 8'h00;
      pop_lo_r          <= 8'h00;
      pop_hi_r          <= 8'h00;
      rdata_dly_r       <= 8'h00;
      mem_we            <= 1'b0;
      mem_re            <= 1'b0;
      mem_addr          <= 16'h0000;
      mem_wdata         <= 8'h00;
      seq_busy          <= 1'b0;
      counter_load      <= 1'b0;
      counter_val       <= 16'h0000;
      bank_select       <= 1'b0;
      master_irq_enable <= 1'b0;
      svc_mask_r        <= 1'b0;
      svc_nmi_r         <= 1'b0;
      acc_nmi_r         <= 1'b0;
      last_slot_r       <= 4'h0;
    end
    else
    begin
      mem_we       <= 1'b0;
      mem_re       <= 1'b0;
      counter_load <= 1'b0;
      // read data one cycle late, so each return step sees its own pop
      rdata_dly_r  <= mem_rdata;
      case (state_r)
        ST_IDLE:
        begin
          if (accept_go)
          begin
            state_r           <= ST_ACC;
            step_r            <= `IAS_ACC_SW;
            seq_busy          <= 1'b1;
            master_irq_enable <= 1'b0;
            saved_cnt_r       <= counter_now;
            vec_addr_r        <= vbase_r + {11'h000, slot, 1'b0};
            last_slot_r       <= slot;
            acc_nmi_r         <= take_nmi;
            mem_we            <= 1'b1;
            mem_addr          <= stack_ptr_r;
            mem_wdata         <= status_word;
            stack_ptr_r       <= stack_ptr_r - 16'h0001;
          end
          else if (return_go)
          begin
            state_r     <= ST_RET;
            step_r      <= 3'h0;
            seq_busy    <= 1'b1;
            svc_mask_r  <= svc_mask_r && !return_from_maskable;
            svc_nmi_r   <= svc_nmi_r && !return_from_nonmaskable;
            mem_re      <= 1'b1;
            mem_addr    <= stack_ptr_r + 16'h0001;
            stack_ptr_r <= stack_ptr_r + 16'h0001;
          end
          else if (push_req)
          begin
            mem_we      <= 1'b1;
            mem_addr    <= stack_ptr_r;
            mem_wdata   <= push_data;
            stack_ptr_r <= stack_ptr_r - 16'h0001;
          end
          else if (pop_req)
          begin
            mem_re      <= 1'b1;
            mem_addr    <= stack_ptr_r + 16'h0001;
            stack_ptr_r <= stack_ptr_r + 16'h0001;
          end
          else
          begin
            if (wr_en && paddr == `IAS_ADDR_STACK)
              stack_ptr_r <= pwdata[15:0];
            if (enable_irq)
              master_irq_enable <= 1'b1;
            else if (disable_irq)
              master_irq_enable <= 1'b0;
            else if (wr_en && paddr == `IAS_ADDR_CTRL)
              master_irq_enable <= pwdata[`IAS_CTRL_MIE];
            if (bank_wr)
              bank_select <= bank_wdata;
            else if (wr_en && paddr == `IAS_ADDR_CTRL)
              bank_select <= pwdata[`IAS_CTRL_BANK];
          end
        end
        ST_ACC:
        begin
          step_r <= step_r + 3'h1;
          case (step_r)
            `IAS_ACC_SW, `IAS_ACC_HI:
            begin
              mem_we      <= 1'b1;
              mem_addr    <= stack_ptr_r;
              mem_wdata   <= (step_r == `IAS_ACC_SW) ? saved_cnt_r[15:8]
                                                     : saved_cnt_r[7:0];
              stack_ptr_r <= stack_ptr_r - 16'h0001;
            end
            `IAS_ACC_VRLO:
            begin
              mem_re   <= 1'b1;
              mem_addr <= vec_addr_r;
            end
            `IAS_ACC_VRHI:
            begin
              mem_re   <= 1'b1;
              mem_addr <= vec_addr_r + 16'h0001;
            end
            `IAS_ACC_VCLO:
              vec_lo_r <= mem_rdata;
            `IAS_ACC_VCHI:
              counter_val <= {mem_rdata, vec_lo_r};
            `IAS_ACC_LAST:
            begin
              counter_load <= 1'b1;
              state_r      <= ST_IDLE;
              seq_busy     <= 1'b0;
              svc_mask_r   <= svc_mask_r || !acc_nmi_r;
              svc_nmi_r    <= svc_nmi_r || acc_nmi_r;
            end
            default:
            begin
            end
          endcase
        end
        ST_RET:
        begin
          step_r <= step_r + 3'h1;
          if (step_r < `IAS_RET_RD2)
          begin
            mem_re      <= 1'b1;
            mem_addr    <= stack_ptr_r + 16'h0001;
            stack_ptr_r <= stack_ptr_r + 16'h0001;
          end
          else if (step_r == `IAS_RET_RD2)
            pop_lo_r <= rdata_dly_r;
          else if (step_r == `IAS_RET_CAPHI)
            pop_hi_r <= rdata_dly_r;
          else
          begin
            // bank comes back from the word
            bank_select       <= rdata_dly_r[`IAS_SW_BANK];
            master_irq_enable <= rdata_dly_r[`IAS_SW_MIE];
            counter_val       <= {pop_hi_r, pop_lo_r};
            counter_load      <= 1'b1;
            state_r           <= ST_IDLE;
            seq_busy          <= 1'b0;
          end
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // apb registers
  // ****************************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      source_enable_flag_r   <= {`IAS_NSRC{1'b0}};
      priority_level_field_r <= {2*`IAS_NSRC{1'b0}};
      vbase_r                <= `IAS_VBASE_RST;
    end
    else if (wr_en)
    begin
      if (paddr == `IAS_ADDR_ENAB)
        source_enable_flag_r <= pwdata[`IAS_NSRC-1:0];
      if (paddr == `IAS_ADDR_PRIO)
        priority_level_field_r <= pwdata[2*`IAS_NSRC-1:0];
      if (paddr == `IAS_ADDR_VBASE)
        vbase_r <= pwdata[15:0];
    end
  end

  always @*
  begin
    rd_mux = 32'h00000000;
    case (paddr)
      `IAS_ADDR_CTRL:  rd_mux = {30'h00000000, bank_select, master_irq_enable};
      `IAS_ADDR_PEND:  rd_mux = {24'h000000, pending_latch_r};
      `IAS_ADDR_ENAB:  rd_mux = {24'h000000, source_enable_flag_r};
      `IAS_ADDR_PRIO:  rd_mux = {16'h0000, priority_level_field_r};
      `IAS_ADDR_STACK: rd_mux = {16'h0000, stack_ptr_r};
      `IAS_ADDR_STAT:  rd_mux = {24'h000000, svc_nmi_r, svc_mask_r, nmi_pend_r,
                                 last_slot_r, seq_busy};
      `IAS_ADDR_VBASE: rd_mux = {16'h0000, vbase_r};
      default:         rd_mux = 32'h00000000;
    endcase
  end

  // no wait state: answer prepared in setup, given in the first access cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !ias_mapped(paddr);
      prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // ****************************************************************
  // banked general registers, never saved by the sequencer
  // ****************************************************************
  // left to software
  ias_bank_file u_banks
  (
    .pclk        (pclk),
    .presetn     (presetn),
    .bank_select (bank_select),
    .gpr_we      (gpr_we),
    .gpr_idx     (gpr_idx),
    .gpr_wdata   (gpr_wdata),
    .gpr_rdata   (gpr_rdata),
    .index_we    (index_we),
    .index_sel   (index_sel),
    .index_wdata (index_wdata),
    .index_rdata (index_rdata)
  );

endmodule
`default_nettype wire

// *** verification/ias_mem_model.sv ***
/*
 * Stack and vector memory beside the sequencer, 256 bytes on the low
 * address byte. Assumes reads answer in the cycle after mem_re.
 */
`timescale 1ns/1ps
`default_nettype none
module ias_mem_model
(
  // clock
  input  wire logic        pclk,
  // memory port
  input  wire logic        mem_we,
  input  wire logic        mem_re,
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  output var  logic [7:0]  mem_rdata
);
  logic [7:0] mem [0:255];

  // each byte starts equal to its own address
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = i[7:0];
    mem_rdata = 8'h00;
  end

  // data line toggles when nothing is read
  always @(posedge pclk)
  begin
    if (mem_we)
      mem[mem_addr[7:0]] <= mem_wdata;
    mem_rdata <= mem_re ? mem[mem_addr[7:0]] : ~mem_rdata;
  end
endmodule
`default_nettype wire

// *** verification/ias_properties.sv ***
/*
 * Timing checks of acceptance and return sequences.
 * Assumes binding onto ias_top, one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module ias_properties
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // sequencer outputs
  input wire logic        seq_busy,
  input wire logic        mem_we,
  input wire logic        mem_re,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0]  mem_wdata,
  input wire logic        counter_load,
  input wire logic        bank_select,
  input wire logic        master_irq_enable
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_acc_len: assert property ($rose(seq_busy) && mem_we |-> seq_busy[*8] ##1 !seq_busy)
    else $error("acceptance length wrong");
  a_mie_low: assert property ($rose(seq_busy) && mem_we |-> !master_irq_enable[*8])
    else $error("master enable not low");
  a_push_seq: assert property ($rose(seq_busy) && mem_we |->
    ##1 mem_we && mem_addr == $past(mem_addr) - 16'h1
    ##1 mem_we && mem_addr == $past(mem_addr) - 16'h1 ##1 !mem_we)
    else $error("push sequence wrong");
  a_sw_saved: assert property ($rose(seq_busy) && mem_we |->
    mem_wdata[7] == $past(master_irq_enable) && mem_wdata[0] == bank_select)
    else $error("status byte wrong");
  a_ret_len: assert property ($rose(seq_busy) && mem_re |-> seq_busy[*5] ##1 !seq_busy)
    else $error("return length wrong");
  a_pop_seq: assert property ($rose(seq_busy) && mem_re |->
    ##1 mem_re && mem_addr == $past(mem_addr) + 16'h1
    ##1 mem_re && mem_addr == $past(mem_addr) + 16'h1)
    else $error("pop sequence wrong");
  a_load_end: assert property ($fell(seq_busy) |-> counter_load)
    else $error("no load at end");
  a_load_only: assert property (counter_load |-> $past(seq_busy) && !seq_busy)
    else $error("stray load");
endmodule
bind ias_top ias_properties u_chk (.pclk, .presetn, .seq_busy, .mem_we, .mem_re, .mem_addr,
  .mem_wdata, .counter_load, .bank_select, .master_irq_enable);
`default_nettype wire

// *** verification/tb.sv ***
/*
 * Self-checking bench of the interrupt sequencer over apb and strobes.
 * Assumes ias_top, ias_mem_model and the bound checker.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0;
  logic        bw = '0, err, pready, pslverr, mem_we, mem_re, seq_busy;
  logic        counter_load, bank_select, master_irq_enable;
  logic [7:0]  paddr = '0, irq = '0, gw = '0, mem_rdata, mem_wdata, gpr_rdata;
  logic [8:0]  stb = '0;
  logic [15:0] mem_addr, counter_val, index_rdata;
  logic [31:0] pwdata = '0, prdata, r;
  int          miscompares = 0, checked = 0;

  always #4 pclk = ~pclk;

  ias_top uut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .irq_pulse(irq), .nmi_pulse(stb[7]), .instr_done(stb[0]), .counter_now(16'h1234),
    .return_from_maskable(stb[1]), .return_from_nonmaskable(stb[2]), .push_req(stb[3]),
    .push_data(gw), .pop_req(stb[4]), .enable_irq(stb[5]), .disable_irq(1'b0),
    .bank_wr(stb[6]), .bank_wdata(bw), .gpr_we(stb[8]), .gpr_idx(3'h3), .gpr_wdata(gw),
    .gpr_rdata, .index_we(stb[8]), .index_sel(bw), .index_wdata({gw, gw}), .index_rdata,
    .mem_rdata, .mem_we, .mem_re, .mem_addr, .mem_wdata, .seq_busy, .counter_load,
    .counter_val, .bank_select, .master_irq_enable);
  ias_mem_model mdl (.pclk, .mem_we, .mem_re, .mem_addr, .mem_wdata, .mem_rdata);

  task print_verdict;
    if (miscompares == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task hang;
    miscompares++;
    print_verdict();
  endtask

  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    if (n == 20)
      hang();
    r   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, '0);
    chk(r, e);
  endtask

  // one-cycle strobes, data and bank level held afterwards
  task pulse(input logic [8:0] s, input logic [7:0] g, input logic b);
    @(posedge pclk);
    stb <= s;
    gw  <= g;
    bw  <= b;
    @(posedge pclk);
    stb <= '0;
  endtask

  task wait_load;
    int n;
    n = 0;
    while (counter_load !== 1'b1 && n < 20)
    begin
      @(negedge pclk);
      n++;
    end
    if (n == 20)
      hang();
  endtask

  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h10, 32'h00FF);
    apb(8'h40, 1'b0, '0);
    chk(err, 1'b1);
    apb(8'h08, 1'b1, 32'h82);
    apb(8'h0C, 1'b1, 32'hC00C);
    @(posedge pclk);
    irq <= 8'h82;
    @(posedge pclk);
    irq <= '0;
    pulse(9'h001, 8'h00, 1'b0);
    @(negedge pclk);
    chk(seq_busy, 1'b0);
    rd(8'h04, 32'h82);
    pulse(9'h100, 8'h5A, 1'b0);
    pulse(9'h040, 8'h5A, 1'b1);
    pulse(9'h100, 8'hA5, 1'b1);
    pulse(9'h040, 8'hA5, 1'b0);
    @(posedge pclk);
    @(negedge pclk);
    chk(gpr_rdata, 8'h5A);
    chk(index_rdata, 16'h5A5A);
    pulse(9'h060, 8'h00, 1'b1);
    pulse(9'h001, 8'h00, 1'b1);
    wait_load();
    chk(counter_val, 16'hD1D0);
    chk(master_irq_enable, 1'b0);
    chk(mdl.mem[8'hFF], 8'h81);
    chk({mdl.mem[8'hFE], mdl.mem[8'hFD]}, 16'h1234);
    rd(8'h04, 32'h02);
    rd(8'h10, 32'h00FC);
    apb(8'h08, 1'b1, 32'h02);
    pulse(9'h040, 8'h00, 1'b0);
    pulse(9'h002, 8'h00, 1'b0);
    wait_load();
    chk(counter_val, 16'h1234);
    chk(bank_select, 1'b1);
    chk(master_irq_enable, 1'b1);
    rd(8'h10, 32'h00FF);
    apb(8'h04, 1'b1, 32'hFD);
    apb(8'h04, 1'b1, 32'hFF);
    rd(8'h04, 32'h00);
    pulse(9'h080, 8'h00, 1'b1);
    pulse(9'h001, 8'h00, 1'b1);
    wait_load();
    chk(counter_val, 16'hC1C0);
    pulse(9'h004, 8'h00, 1'b1);
    wait_load();
    chk(counter_val, 16'h1234);
    pulse(9'h008, 8'h3C, 1'b1);
    rd(8'h10, 32'h00FE);
    chk(mdl.mem[8'hFF], 8'h3C);
    pulse(9'h010, 8'h00, 1'b1);
    rd(8'h10, 32'h00FF);
    apb(8'h00, 1'b1, 32'h0);
    apb(8'h10, 1'b1, 32'h0080);
    rd(8'h10, 32'h0080);
    print_verdict();
  end
endmodule
`default_nettype wire
